//--- bench/smcopt_mem_model.sv
// behavioural asynchronous memory that watches the strobes and measures each access
`timescale 1ns/1ps
`default_nettype none
module smcopt_mem_model
    import smcopt_pkg::*;
(
    input wire logic clk_sys, // system clock
    input wire logic rst_b, // async reset, active low
    input wire logic chipSelectN, // chip select
    input wire logic readStrobeN, // read strobe
    input wire logic writeStrobeN, // single write strobe
    input wire logic [3:0] byteSelectN, // byte selects
    input wire logic [3:0] byteWriteStrobeN, // per-byte write strobes
    input wire logic floatBusy, // bus held after a read
    output logic [7:0] readPulse, // cycles of the last read strobe pulse
    output logic [3:0] selLanes, // byte selects seen in this access
    output logic [3:0] wrLanes, // byte write strobes seen in this access
    output logic weSeen, // single write strobe seen in this access
    output logic [4:0] floatLen, // cycles of the last float period
    output logic csUnderFloat, // chip select fell while the bus was held
    output logic floatAfterCs // float began with chip select already high
);
    logic prevCs; // chip select one cycle back
    logic prevRd; // read strobe one cycle back
    logic prevFloat; // float flag one cycle back
    logic [7:0] rdRun; // running read pulse count
    logic [4:0] floatRun; // running float count
    // the model drives no data lines, so nothing can be left stale between accesses
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            prevCs <= 1'b1;
            prevRd <= 1'b1;
            prevFloat <= 1'b0;
            rdRun <= 8'h00;
            floatRun <= 5'h00;
            readPulse <= 8'h00;
            selLanes <= 4'h0;
            wrLanes <= 4'h0;
            weSeen <= 1'b0;
            floatLen <= 5'h00;
            csUnderFloat <= 1'b0;
            floatAfterCs <= 1'b0;
        end
        else
        begin
            prevCs <= chipSelectN;
            prevRd <= readStrobeN;
            prevFloat <= floatBusy;
            // a falling chip select opens a fresh record of lanes
            if (prevCs && !chipSelectN)
            begin
                selLanes <= ~byteSelectN;
                wrLanes <= ~byteWriteStrobeN;
                weSeen <= ~writeStrobeN;
                csUnderFloat <= floatBusy;
            end
            else if (!chipSelectN)
            begin
                selLanes <= selLanes | ~byteSelectN;
                wrLanes <= wrLanes | ~byteWriteStrobeN;
                weSeen <= weSeen | ~writeStrobeN;
            end
            rdRun <= readStrobeN ? 8'h00 : rdRun + 8'h01;
            if (readStrobeN && !prevRd)
                readPulse <= rdRun;
            floatRun <= floatBusy ? floatRun + 5'h01 : 5'h00;
            if (!floatBusy && prevFloat)
                floatLen <= floatRun;
            if (floatBusy && !prevFloat)
                floatAfterCs <= chipSelectN;
        end
    end
endmodule // smcopt_mem_model
`default_nettype wire

//--- bench/smcopt_top_test.sv
// self-checking testbench of the chip-select option block
`timescale 1ns/1ps
`default_nettype none
module smcopt_top_test
    import smcopt_pkg::*;
;
    logic clk_sys, rst_b, byteAccessType, floatOptimiseEnable, pageReadEnable, readMode;
    logic [1:0] dataBusWidth, pageSizeSel;
    logic [3:0] dataFloatCycles, reqByteEn;
    logic [6:0] setupLen, writePulseLen, readStrobePulseLen, csReadPulseLen, holdLen;
    logic reqValid, reqWrite, accessDone, busWidthReserved, floatBusy;
    logic [27:0] reqAddr, base;
    logic chipSelectN, readStrobeN, writeStrobeN, weSeen, csUnderFloat, floatAfterCs;
    logic [3:0] byteSelectN, byteWriteStrobeN, selLanes, wrLanes;
    logic [7:0] readPulse;
    logic [4:0] floatLen;
    logic [3:0] floatSet [4] = '{4'h0, 4'h1, 4'h7, 4'hf}; // float values incl. both ends
    int error_cnt = 0;
    int check_count = 0;
    smcopt_top #(.ADDR_W(28), .LEN_W(7)) uut (.clk_sys(clk_sys), .rst_b(rst_b),
        .byteAccessType(byteAccessType), .dataBusWidth(dataBusWidth), .dataFloatCycles(dataFloatCycles),
        .floatOptimiseEnable(floatOptimiseEnable), .pageReadEnable(pageReadEnable),
        .pageSizeSel(pageSizeSel), .readMode(readMode), .setupLen(setupLen),
        .writePulseLen(writePulseLen), .readStrobePulseLen(readStrobePulseLen),
        .csReadPulseLen(csReadPulseLen), .holdLen(holdLen), .reqValid(reqValid), .reqWrite(reqWrite),
        .reqAddr(reqAddr), .reqByteEn(reqByteEn), .accessDone(accessDone),
        .busWidthReserved(busWidthReserved), .floatBusy(floatBusy), .chipSelectN(chipSelectN),
        .readStrobeN(readStrobeN), .writeStrobeN(writeStrobeN), .byteSelectN(byteSelectN),
        .byteWriteStrobeN(byteWriteStrobeN));
    smcopt_mem_model mem (.clk_sys(clk_sys), .rst_b(rst_b), .chipSelectN(chipSelectN),
        .readStrobeN(readStrobeN), .writeStrobeN(writeStrobeN), .byteSelectN(byteSelectN),
        .byteWriteStrobeN(byteWriteStrobeN), .floatBusy(floatBusy), .readPulse(readPulse),
        .selLanes(selLanes), .wrLanes(wrLanes), .weSeen(weSeen), .floatLen(floatLen),
        .csUnderFloat(csUnderFloat), .floatAfterCs(floatAfterCs));
    // 250 MHz system clock
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // prints the counts and the verdict, then stops
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // single-bit compare
    task automatic check_bit(input string what, input logic exp, input logic got);
        check_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("FAIL %s expected %b seen %b", what, exp, got);
        end
    endtask
    // byte-wide compare for lanes and counts
    task automatic check_val(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one access: fields held until the done pulse, reqValid dropped at the edge after it
    task automatic access(input logic wr, input logic [27:0] addr, input logic [3:0] be);
        int n;
        @(posedge clk_sys);
        reqValid <= 1'b1;
        reqWrite <= wr;
        reqAddr <= addr;
        reqByteEn <= be;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        while (accessDone !== 1'b1 && n < 500);
        check_bit("access completes", 1'b1, accessDone);
        @(posedge clk_sys);
        reqValid <= 1'b0;
    endtask
    // waits a bounded time for the float period to end
    task automatic wait_float_clear();
        int n;
        n = 0;
        #1;
        while (floatBusy !== 1'b0 && n < 100)
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        repeat (2) @(posedge clk_sys);
        #1;
    endtask
    // one access under a strobe scheme and width, then the lanes the memory saw
    task automatic lane_case(input logic acc, input logic [1:0] bw, input logic wr, input logic [3:0] be,
        input logic [3:0] expSel, input logic [3:0] expWr, input logic expWe);
        @(posedge clk_sys);
        byteAccessType <= acc;
        dataBusWidth <= bw;
        access(wr, 28'h0000100, be);
        check_val("byte selects", {4'h0, expSel}, {4'h0, selLanes});
        check_val("byte write strobes", {4'h0, expWr}, {4'h0, wrLanes});
        check_bit("single write strobe", expWe, weSeen);
        if (!wr)
            check_val("standard read pulse", 8'h02, readPulse);
    endtask
    // main sequence
    initial
    begin
        rst_b = 1'b0;
        {byteAccessType, floatOptimiseEnable, pageReadEnable, readMode, reqValid, reqWrite} = 6'h00;
        {dataBusWidth, pageSizeSel, dataFloatCycles, reqByteEn} = 12'h200;
        {setupLen, writePulseLen, readStrobePulseLen} = {7'h01, 7'h02, 7'h02};
        {csReadPulseLen, holdLen, reqAddr} = {7'h05, 7'h01, 28'h0000000};
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        #1;
        check_val("idle strobes", 8'hff, {byteSelectN, byteWriteStrobeN});
        check_val("idle controls", 8'h07, {3'h0, accessDone, floatBusy, chipSelectN, readStrobeN, writeStrobeN});
        lane_case(SMCOPT_ACC_SELECT, SMCOPT_BW_32, 1'b1, 4'h5, 4'h5, 4'h0, 1'b1);
        lane_case(SMCOPT_ACC_WRITE, SMCOPT_BW_32, 1'b1, 4'ha, 4'h0, 4'ha, 1'b0);
        lane_case(SMCOPT_ACC_WRITE, SMCOPT_BW_32, 1'b0, 4'hf, 4'h0, 4'h0, 1'b0);
        lane_case(SMCOPT_ACC_SELECT, SMCOPT_BW_16, 1'b0, 4'h6, 4'h2, 4'h0, 1'b0);
        lane_case(SMCOPT_ACC_WRITE, SMCOPT_BW_16, 1'b1, 4'hf, 4'h0, 4'h3, 1'b0);
        lane_case(SMCOPT_ACC_WRITE, SMCOPT_BW_8, 1'b1, 4'hf, 4'h0, 4'h0, 1'b1);
        lane_case(SMCOPT_ACC_SELECT, SMCOPT_BW_8, 1'b0, 4'hf, 4'h0, 4'h0, 1'b0);
        lane_case(SMCOPT_ACC_SELECT, SMCOPT_BW_RSVD, 1'b1, 4'h9, 4'h9, 4'h0, 1'b1);
        for (int w = 0; w < 4; w++)
        begin
            @(posedge clk_sys);
            dataBusWidth <= w[1:0];
            repeat (2) @(posedge clk_sys);
            #1;
            check_bit("reserved width flag", w == 3, busWidthReserved);
        end
        // float period for both read modes and the ends of the field
        for (int m = 0; m < 2; m++)
            for (int i = 0; i < 4; i++)
            begin
                @(posedge clk_sys);
                dataFloatCycles <= floatSet[i];
                readMode <= m[0];
                access(1'b0, 28'h0000200, 4'hf);
                wait_float_clear();
                check_val("float length", {3'h0, floatSet[i] + 5'h01}, {3'h0, floatLen});
                check_bit("float after chip select", ~m[0], floatAfterCs);
            end
        // next access right behind a read, plain and optimised
        for (int o = 0; o < 2; o++)
        begin
            @(posedge clk_sys);
            dataFloatCycles <= 4'h8;
            setupLen <= 7'h02;
            floatOptimiseEnable <= o[0];
            access(1'b0, 28'h0000300, 4'hf);
            access(1'b1, 28'h0000300, 4'hf);
            check_bit("chip select under float", o[0], csUnderFloat);
            wait_float_clear();
        end
        // page reads: first, same page at its last byte, then the next page
        @(posedge clk_sys);
        dataFloatCycles <= 4'h0;
        floatOptimiseEnable <= 1'b0;
        pageReadEnable <= 1'b1;
        for (int p = 0; p < 4; p++)
        begin
            @(posedge clk_sys);
            pageSizeSel <= p[1:0];
            base = 28'h0001000 << p;
            access(1'b0, base, 4'hf);
            check_val("first page read", 8'h05, readPulse);
            access(1'b0, base + (28'h0000004 << p) - 28'h0000001, 4'hf);
            check_val("same page read", 8'h02, readPulse);
            access(1'b0, base + (28'h0000004 << p), 4'hf);
            check_val("next page read", 8'h05, readPulse);
        end
        @(posedge clk_sys);
        pageReadEnable <= 1'b0;
        access(1'b0, base, 4'hf);
        check_val("read with pages off", 8'h02, readPulse);
        complete_run();
    end
    // watchdog well beyond the expected run of under a thousand cycles
    initial
    begin
        #100us;
        error_cnt++;
        complete_run();
    end
endmodule // smcopt_top_test
`default_nettype wire

//--- hw/smcopt_float_timer.sv
// data float timer: marks the external bus busy for the float cycles plus turnaround
`timescale 1ns/1ps
`default_nettype none
module smcopt_float_timer
    import smcopt_pkg::*;
(
    input wire logic clk_sys, // system clock
    input wire logic rst_b, // async reset, active low
    input wire logic start, // rising edge of the read controlling signal
    input wire logic [SMCOPT_FLOAT_W-1:0] floatCycles, // programmed float cycles
    output logic busy // bus held from other chip selects
);
    typedef struct packed {
        logic [4:0] cnt; // cycles still to hold
        logic busy; // registered busy flag
    } smcopt_ft_s;

    smcopt_ft_s r_ff;
    smcopt_ft_s nxt_r;

    // load float plus one turnaround cycle, then count down
    always_comb
    begin
        nxt_r = r_ff;
        if (start)
        begin
            nxt_r.cnt = {1'b0, floatCycles} + SMCOPT_FLOAT_TURN;
            nxt_r.busy = 1'b1;
        end
        else if (r_ff.cnt > 5'h01)
        begin
            nxt_r.cnt = r_ff.cnt - 5'h01;
        end
        else
        begin
            nxt_r.cnt = 5'h00;
            nxt_r.busy = 1'b0;
        end
    end

    // state register
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            r_ff <= '0;
        else
            r_ff <= nxt_r;
    end

    assign busy = r_ff.busy;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    // zero float cycles still hold the bus for exactly one cycle
    sequence s_zeroStart;
        start && floatCycles == 4'h0 ##1 !start;
    endsequence
    property p_zeroFloat;
        s_zeroStart |-> busy ##1 (!busy || start);
    endproperty
    a_zeroFloat: assert property (p_zeroFloat) else $error("float hold not one cycle");

    // full float of fifteen still holds the bus eight cycles after the start
    property p_maxFloat;
        (start && floatCycles == 4'hf) ##1 (!start)[*8] |-> busy;
    endproperty
    a_maxFloat: assert property (p_maxFloat) else $error("float hold ended early");
endmodule // smcopt_float_timer
`default_nettype wire

//--- hw/smcopt_pkg.sv
// shared constants and state type of the static memory chip-select option block
package smcopt_pkg;
    // data bus width field codes
    localparam logic [1:0] SMCOPT_BW_8 = 2'h0;
    localparam logic [1:0] SMCOPT_BW_16 = 2'h1;
    localparam logic [1:0] SMCOPT_BW_32 = 2'h2;
    localparam logic [1:0] SMCOPT_BW_RSVD = 2'h3;
    // byte access type field codes
    localparam logic SMCOPT_ACC_SELECT = 1'h0;
    localparam logic SMCOPT_ACC_WRITE = 1'h1;
    // page size field codes, page of 4, 8, 16, 32 bytes
    localparam logic [1:0] SMCOPT_PG_4 = 2'h0;
    localparam logic [1:0] SMCOPT_PG_8 = 2'h1;
    localparam logic [1:0] SMCOPT_PG_16 = 2'h2;
    localparam logic [1:0] SMCOPT_PG_32 = 2'h3;
    // float timing: field width and the fixed turnaround cycle
    localparam int SMCOPT_FLOAT_W = 4;
    localparam logic [4:0] SMCOPT_FLOAT_TURN = 5'h01;
    // reset values of the strobe pins (all inactive high)
    localparam logic [3:0] SMCOPT_LANES_OFF = 4'hf;
    // access sequencer states
    typedef enum logic [1:0] {SM_IDLE, SM_SETUP, SM_PULSE, SM_HOLD} smcopt_state_e;
endpackage : smcopt_pkg

//--- hw/smcopt_strobe_decode.sv
// strobe scheme decode: maps phase and options onto the active-low memory pins
`timescale 1ns/1ps
`default_nettype none
module smcopt_strobe_decode
    import smcopt_pkg::*;
(
    input wire logic byteAccessType, // 1 byte write scheme, 0 byte select scheme
    input wire logic [1:0] dataBusWidth, // bus width code
    input wire logic isWrite, // access is a write
    input wire logic [3:0] byteEn, // byte lanes wanted
    input wire logic csOn, // chip select phase active
    input wire logic strobeOn, // pulse phase active
    output logic csN, // chip select
    output logic rdN, // read strobe
    output logic weN, // single write strobe
    output logic [3:0] bsN, // byte selects
    output logic [3:0] wrN // per-byte write strobes
);
    // lanes that exist on the chosen bus; reserved width behaves as 32 bits
    function automatic logic [3:0] laneMask(input logic [1:0] bw, input logic [3:0] be);
        case (bw)
            SMCOPT_BW_8: laneMask = be & 4'h1;
            SMCOPT_BW_16: laneMask = be & 4'h3;
            default: laneMask = be;
        endcase
    endfunction

    logic wide; // bus is 16 or 32 bits
    logic useByteWrite; // byte write scheme really applies
    logic [3:0] lanes; // active lanes

    // the access type choice only counts on a wide bus
    always_comb
    begin
        wide = (dataBusWidth != SMCOPT_BW_8);
        useByteWrite = wide && (byteAccessType == SMCOPT_ACC_WRITE);
        lanes = laneMask(dataBusWidth, byteEn);
        csN = !csOn;
        rdN = !(csOn && strobeOn && !isWrite);
        weN = !(strobeOn && isWrite && !useByteWrite);
        // per-byte write strobes only in byte write scheme
        wrN = (strobeOn && isWrite && useByteWrite) ? ~lanes : SMCOPT_LANES_OFF;
        // byte selects follow the whole chip select frame on a wide bus, never in byte write scheme
        bsN = (csOn && wide && !useByteWrite) ? ~lanes : SMCOPT_LANES_OFF;
    end
endmodule // smcopt_strobe_decode
`default_nettype wire

//--- hw/smcopt_top.sv
// static memory chip-select options: strobe scheme, width, float time, page reads
// Behaviour
// - access type only applies on wide bus
// - byte write scheme writes with per-lane byte strobes
// - byte write scheme reads with select, read only
// - byte select scheme writes with strobe plus selects
// - byte select scheme reads with selects too
// - width code 8, 16, 32 bits, reserved
// - float field holds 0 to 15 cycles
// - one turnaround cycle follows float period
// - bus held for float cycles plus one
// - optimised float overlaps next access setup
// - plain float waits fully before a next access other than a page hit
// - page enable selects burst page reads
// - page size code gives 4 to 32 bytes
// - first page access timed by chip select pulse
// - later page accesses timed by read pulse
// - read mode picks which rising edge starts float
`timescale 1ns/1ps
`default_nettype none
module smcopt_top
    import smcopt_pkg::*;
#(
    parameter int ADDR_W = 28, // byte address width
    parameter int LEN_W = 7 // width of setup, pulse and hold lengths
)
(
    input wire logic clk_sys, // system clock, 250 MHz
    input wire logic rst_b, // async reset, active low
    input wire logic byteAccessType, // byte_access_type option
    input wire logic [1:0] dataBusWidth, // data_bus_width option
    input wire logic [SMCOPT_FLOAT_W-1:0] dataFloatCycles, // data_float_cycles option
    input wire logic floatOptimiseEnable, // float_optimise_enable option
    input wire logic pageReadEnable, // page_read_enable option
    input wire logic [1:0] pageSizeSel, // page_size_sel option
    input wire logic readMode, // 1 read strobe controls read, 0 chip select
    input wire logic [LEN_W-1:0] setupLen, // setup cycles
    input wire logic [LEN_W-1:0] writePulseLen, // write pulse cycles, at least 1
    input wire logic [LEN_W-1:0] readStrobePulseLen, // read_strobe_pulse_len, at least 1
    input wire logic [LEN_W-1:0] csReadPulseLen, // cs_read_pulse_len, at least 1
    input wire logic [LEN_W-1:0] holdLen, // hold cycles
    input wire logic reqValid, // access request, held until accessDone
    input wire logic reqWrite, // request is a write
    input wire logic [ADDR_W-1:0] reqAddr, // request byte address
    input wire logic [3:0] reqByteEn, // request byte lanes
    output logic accessDone, // one-cycle pulse at end of access
    output logic busWidthReserved, // width code is the reserved one
    output logic floatBusy, // bus held for other chip selects
    output logic chipSelectN, // chip_select_n
    output logic readStrobeN, // read_strobe_n
    output logic writeStrobeN, // write_strobe_n
    output logic [3:0] byteSelectN, // byte0..3_select_n
    output logic [3:0] byteWriteStrobeN // byte0..3_write_strobe_n
);
    // page tag: address with the in-page bits cleared
    function automatic logic [ADDR_W-1:0] pageTag(input logic [ADDR_W-1:0] a, input logic [1:0] pg);
        case (pg)
            SMCOPT_PG_4: pageTag = {a[ADDR_W-1:2], 2'h0};
            SMCOPT_PG_8: pageTag = {a[ADDR_W-1:3], 3'h0};
            SMCOPT_PG_16: pageTag = {a[ADDR_W-1:4], 4'h0};
            default: pageTag = {a[ADDR_W-1:5], 5'h0};
        endcase
    endfunction

    typedef struct packed {
        smcopt_state_e st; // sequencer state
        logic [LEN_W-1:0] cnt; // cycles left in phase
        logic isWrite; // captured direction
        logic [3:0] byteEn; // captured lanes
        logic pageValid; // a page is open
        logic [ADDR_W-1:0] openPage; // tag of open page
        logic done; // end of access pulse
        logic rsvd; // reserved width flag
        logic csN; // pin registers
        logic rdN;
        logic weN;
        logic [3:0] bsN;
        logic [3:0] wrN;
    } smcopt_top_s;

    smcopt_top_s r_ff;
    smcopt_top_s nxt_r;

    logic pageRead; // request is a page mode read
    logic pageHit; // request continues the open page
    logic canStart; // float gate lets the access begin
    logic take; // request accepted this cycle
    logic floatStart; // read controlling signal rises
    logic decCsN; // decoded pins for the next state
    logic decRdN;
    logic decWeN;
    logic [3:0] decBsN;
    logic [3:0] decWrN;

    // page decision and float gate for a waiting request
    always_comb
    begin
        pageRead = pageReadEnable && !reqWrite;
        pageHit = pageRead && r_ff.pageValid
            && (pageTag(reqAddr, pageSizeSel) == r_ff.openPage);
        // a page hit keeps the bus, so no float gate; optimised mode overlaps setup
        canStart = pageHit || !floatBusy || floatOptimiseEnable;
        take = (r_ff.st == SM_IDLE) && reqValid && !r_ff.done && canStart;
    end

    // access sequencer: idle, setup, pulse, hold
    always_comb
    begin
        nxt_r = r_ff;
        nxt_r.done = 1'b0;
        nxt_r.rsvd = (dataBusWidth == SMCOPT_BW_RSVD);
        floatStart = 1'b0;
        case (r_ff.st)
            SM_IDLE:
            begin
                // done still high means the request just served is still on the port
                if (take)
                begin
                    nxt_r.isWrite = reqWrite;
                    nxt_r.byteEn = reqByteEn;
                    if (pageHit)
                    begin
                        nxt_r.st = SM_PULSE;
                        nxt_r.cnt = readStrobePulseLen - 1'b1;
                    end
                    else
                    begin
                        nxt_r.st = SM_SETUP;
                        nxt_r.cnt = setupLen;
                    end
                    // open or drop the page
                    nxt_r.pageValid = pageRead;
                    nxt_r.openPage = pageTag(reqAddr, pageSizeSel);
                end
            end
            SM_SETUP:
            begin
                // setup may overlap the float, but the pulse never starts inside it
                if (r_ff.cnt != '0)
                    nxt_r.cnt = r_ff.cnt - 1'b1;
                else if (!floatBusy)
                begin
                    nxt_r.st = SM_PULSE;
                    if (r_ff.isWrite)
                        nxt_r.cnt = writePulseLen - 1'b1;
                    else if (pageReadEnable)
                        nxt_r.cnt = csReadPulseLen - 1'b1;
                    else
                        nxt_r.cnt = readStrobePulseLen - 1'b1;
                end
            end
            SM_PULSE:
            begin
                if (r_ff.cnt != '0)
                    nxt_r.cnt = r_ff.cnt - 1'b1;
                else
                begin
                    nxt_r.st = SM_HOLD;
                    nxt_r.cnt = holdLen;
                    floatStart = !r_ff.isWrite && readMode;
                end
            end
            SM_HOLD:
            begin
                if (r_ff.cnt != '0)
                    nxt_r.cnt = r_ff.cnt - 1'b1;
                else
                begin
                    nxt_r.st = SM_IDLE;
                    nxt_r.done = 1'b1;
                    floatStart = !r_ff.isWrite && !readMode;
                end
            end
            default:
            begin
                nxt_r.st = SM_IDLE;
            end
        endcase
        // pins follow the next state so they leave flip-flops aligned with it
        nxt_r.csN = decCsN;
        nxt_r.rdN = decRdN;
        nxt_r.weN = decWeN;
        nxt_r.bsN = decBsN;
        nxt_r.wrN = decWrN;
    end

    // pin scheme decode for the coming state
    smcopt_strobe_decode u_decode (
        .byteAccessType(byteAccessType),
        .dataBusWidth(dataBusWidth),
        .isWrite(nxt_r.isWrite),
        .byteEn(nxt_r.byteEn),
        .csOn(nxt_r.st != SM_IDLE),
        .strobeOn(nxt_r.st == SM_PULSE),
        .csN(decCsN),
        .rdN(decRdN),
        .weN(decWeN),
        .bsN(decBsN),
        .wrN(decWrN)
    );

    // float period after each read, shared by every chip select
    smcopt_float_timer u_float (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .start(floatStart),
        .floatCycles(dataFloatCycles),
        .busy(floatBusy)
    );

    // state register; pins reset inactive
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            r_ff <= '0;
            r_ff.st <= SM_IDLE;
            r_ff.csN <= 1'b1;
            r_ff.rdN <= 1'b1;
            r_ff.weN <= 1'b1;
            r_ff.bsN <= SMCOPT_LANES_OFF;
            r_ff.wrN <= SMCOPT_LANES_OFF;
        end
        else
        begin
            r_ff <= nxt_r;
        end
    end

    assign accessDone = r_ff.done;
    assign busWidthReserved = r_ff.rsvd;
    assign chipSelectN = r_ff.csN;
    assign readStrobeN = r_ff.rdN;
    assign writeStrobeN = r_ff.weN;
    assign byteSelectN = r_ff.bsN;
    assign byteWriteStrobeN = r_ff.wrN;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    logic wideNow; // helper: bus wider than 8 bits
    assign wideNow = (dataBusWidth != SMCOPT_BW_8);

    property p_narrowNoByteWr;
        !wideNow && $stable(dataBusWidth) |-> byteWriteStrobeN == 4'hf;
    endproperty
    a_narrowNoByteWr: assert property (p_narrowNoByteWr) else $error("byte write strobes on 8-bit bus");

    property p_byteWrite;
        wideNow && byteAccessType && r_ff.st == SM_PULSE && r_ff.isWrite && r_ff.byteEn[0]
            |-> writeStrobeN && !byteWriteStrobeN[0];
    endproperty
    a_byteWrite: assert property (p_byteWrite) else $error("byte write scheme misdriven");

    property p_bwRead;
        wideNow && byteAccessType && !r_ff.isWrite |-> byteSelectN == 4'hf;
    endproperty
    a_bwRead: assert property (p_bwRead) else $error("byte selects driven in byte write read");

    property p_bsWrite;
        wideNow && !byteAccessType && r_ff.st == SM_PULSE && r_ff.isWrite
            |-> !writeStrobeN && byteWriteStrobeN == 4'hf;
    endproperty
    a_bsWrite: assert property (p_bsWrite) else $error("byte select write misdriven");

    property p_bsRead;
        wideNow && !byteAccessType && r_ff.st == SM_PULSE && !r_ff.isWrite && r_ff.byteEn[0]
            |-> !readStrobeN && !byteSelectN[0];
    endproperty
    a_bsRead: assert property (p_bsRead) else $error("byte select read misdriven");

    property p_plainWait;
        r_ff.st == SM_IDLE && floatBusy && !floatOptimiseEnable && !pageHit |=> r_ff.st == SM_IDLE;
    endproperty
    a_plainWait: assert property (p_plainWait) else $error("access started inside float");

    property p_optOverlap;
        take && floatBusy && floatOptimiseEnable && !pageHit |=> r_ff.st == SM_SETUP;
    endproperty
    a_optOverlap: assert property (p_optOverlap) else $error("optimised float did not overlap");

    property p_noPulseInFloat;
        r_ff.st == SM_SETUP && r_ff.cnt == '0 && floatBusy |=> r_ff.st == SM_SETUP;
    endproperty
    a_noPulseInFloat: assert property (p_noPulseInFloat) else $error("pulse began inside float");

    property p_pageLater;
        take && pageHit |=> r_ff.st == SM_PULSE && r_ff.cnt == readStrobePulseLen - 1'b1;
    endproperty
    a_pageLater: assert property (p_pageLater) else $error("page hit wrongly timed");

    sequence s_readPulseEnd;
        r_ff.st == SM_PULSE && r_ff.cnt == '0 && !r_ff.isWrite && readMode;
    endsequence
    property p_floatOnStrobe;
        s_readPulseEnd |=> floatBusy && r_ff.st == SM_HOLD;
    endproperty
    a_floatOnStrobe: assert property (p_floatOnStrobe) else $error("float not started at strobe rise");
endmodule // smcopt_top
`default_nettype wire
